// File: timekeeping_sram_rtc.sv
// Byte-wide static RAM with a BCD calendar clock in its top eight bytes
// Summary of operation
// - Behaves as a 32768 by 8 asynchronous static RAM.
// - Clock bytes live at the top eight addresses, same bus cycles.
// - Time and date kept as packed BCD, hours 00 to 23.
// - Month lengths and leap day handled, correct through 2099.
// - Visible bytes copy hidden counters; counters never stop for access.
// - Read-halt bit set suspends the copy into visible bytes.
// - Visible bytes keep the time present when halt was written.
// - Halt cleared: all visible bytes refresh together within a second.
// - Write-halt bit set suspends updates so software can load time.
// - Write-halt cleared loads visible values into the counters.
// - Seconds bit 7 stops the time base when one.
// - Weekday bit 6 makes seconds bit 0 toggle at 512 Hz.
// - Sustained seconds read shows the 512 Hz toggle on data bit 0.
// - Supply fail deselects the part: all accesses ignored.
// - Read when selected with write strobe high; drive only with OE low.
// - Write starts at later fall of strobe or select; address held.
// - Supply-fail output low while supply is below the fail point.
// - Unused clock byte bits act as ordinary memory bits.
`timescale 1ns/1ps
module timekeeping_sram_rtc #(
    parameter int unsigned TICK_CYCLES = rtc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Memory bus pins
    input wire logic [14:0] address_lines,
    input wire logic chipSel_n,
    input wire logic outEn_n,
    input wire logic writeEn_n,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    // Supply monitor
    input wire logic supplyLow,
    output logic supply_fail_out_n
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0][7:0] vis;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] wday;
        logic [7:0] date;
        logic [7:0] mon;
        logic [7:0] year;
        logic [19:0] prescale;
        logic [8:0] probeCnt;
        logic probeLsb;
        logic wrActive;
        logic [14:0] wrAddr;
        logic [7:0] wrData;
        logic [7:0] dataOut;
        logic dataOe;
        logic failOut_n;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic [7:0] mem [0:rtc_pkg::MEM_DEPTH-1];
    logic [3:0] pinsS;
    logic [14:0] addrS;
    logic [7:0] dataS;
    logic memWrite;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    pin_sync3 #(.W(4), .RESET_VAL(rtc_pkg::PIN_IDLE)) ctrlSync (
        .clock(clock),
        .arst_n(arst_n),
        .pinIn({supplyLow, chipSel_n, outEn_n, writeEn_n}),
        .pinOut(pinsS)
    );

    pin_sync3 #(.W(15), .RESET_VAL(15'h0000)) addrSync (
        .clock(clock),
        .arst_n(arst_n),
        .pinIn(address_lines),
        .pinOut(addrS)
    );

    pin_sync3 #(.W(8), .RESET_VAL(8'h00)) dataSync (
        .clock(clock),
        .arst_n(arst_n),
        .pinIn(dataIn),
        .pinOut(dataS)
    );

    // ------------------------------------------------------------
    // BCD helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcdInc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcdInc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // Year 2000 counts as leap, so a two-digit year divisible by 4 is
    // enough up to 2099
    function automatic logic isLeap(input logic [7:0] y);
        if (y[4]) begin
            isLeap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            isLeap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                     (y[3:0] == 4'h8);
        end
    endfunction

    function automatic logic [7:0] monthEnd(input logic [7:0] m,
                                            input logic [7:0] y);
        case (m)
            8'h02: monthEnd = isLeap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: monthEnd = 8'h30;
            default: monthEnd = 8'h31;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic failS;
    logic selS;
    logic oeS;
    logic weS;
    logic nowWrite;
    logic commit;
    logic wrIsClk;
    logic tick;
    logic secTick;
    logic halted;
    logic [7:0] rdVal;
    logic [7:0] mask;
    logic [63:0] cntBytes;

    always_comb begin
        s_next = s_reg;
        failS = pinsS[3];
        selS = !pinsS[2];
        oeS = !pinsS[1];
        weS = !pinsS[0];
        rdVal = 8'h00;
        mask = 8'h00;
        cntBytes = {s_reg.year, s_reg.mon, s_reg.date, s_reg.wday,
                    s_reg.hour, s_reg.min, s_reg.sec, 8'h00};

        // A write spans select and strobe both low; it lands when it ends
        nowWrite = selS && weS && !failS;
        commit = s_reg.wrActive && !nowWrite && !failS;
        s_next.wrActive = nowWrite;
        if (nowWrite) begin
            s_next.wrAddr = addrS;
            s_next.wrData = dataS;
        end
        wrIsClk = s_reg.wrAddr >= rtc_pkg::CLOCK_BASE;
        memWrite = commit && !wrIsClk;

        // Time base; the stop bit freezes the prescaler so that clearing it
        // resumes from the held time
        tick = !s_reg.vis[rtc_pkg::IDX_SEC][rtc_pkg::CRYSTAL_HALT_BIT] &&
               (s_reg.prescale == 20'(TICK_CYCLES - 1));
        secTick = tick && (s_reg.probeCnt == rtc_pkg::PROBE_LAST);
        if (!s_reg.vis[rtc_pkg::IDX_SEC][rtc_pkg::CRYSTAL_HALT_BIT]) begin
            s_next.prescale = tick ? 20'h00000 : s_reg.prescale + 20'h00001;
        end
        if (tick) begin
            s_next.probeCnt = s_reg.probeCnt + 9'h001;
            if (s_reg.vis[rtc_pkg::IDX_WDAY][rtc_pkg::RATE_PROBE_BIT]) begin
                s_next.probeLsb = !s_reg.probeLsb;
            end
        end

        // Calendar advance runs regardless of read or write halts or bus traffic, but not while the stop bit is set
        if (secTick) begin
            if (s_reg.sec >= rtc_pkg::MAX_SEC) begin
                s_next.sec = rtc_pkg::RST_ZERO;
                if (s_reg.min >= rtc_pkg::MAX_SEC) begin
                    s_next.min = rtc_pkg::RST_ZERO;
                    if (s_reg.hour >= rtc_pkg::MAX_HOUR) begin
                        s_next.hour = rtc_pkg::RST_ZERO;
                        s_next.wday = (s_reg.wday >= rtc_pkg::MAX_WDAY) ?
                                      rtc_pkg::RST_ONE : bcdInc(s_reg.wday);
                        if (s_reg.date >= monthEnd(s_reg.mon, s_reg.year))
                        begin
                            s_next.date = rtc_pkg::RST_ONE;
                            if (s_reg.mon >= rtc_pkg::MAX_MON) begin
                                s_next.mon = rtc_pkg::RST_ONE;
                                s_next.year = (s_reg.year >= rtc_pkg::MAX_YEAR)
                                    ? rtc_pkg::RST_ZERO : bcdInc(s_reg.year);
                            end else begin
                                s_next.mon = bcdInc(s_reg.mon);
                            end
                        end else begin
                            s_next.date = bcdInc(s_reg.date);
                        end
                    end else begin
                        s_next.hour = bcdInc(s_reg.hour);
                    end
                end else begin
                    s_next.min = bcdInc(s_reg.min);
                end
            end else begin
                s_next.sec = bcdInc(s_reg.sec);
            end
        end

        // Copy counters into the visible bytes every cycle unless halted;
        // only counter-owned bits move, spare bits stay as memory
        halted = s_reg.vis[rtc_pkg::IDX_CTRL][rtc_pkg::WR_HALT_BIT] ||
                 s_reg.vis[rtc_pkg::IDX_CTRL][rtc_pkg::RD_HALT_BIT];
        if (!halted) begin
            for (int i = 1; i < 8; i++) begin
                mask = rtc_pkg::TIME_MASKS[i*8 +: 8];
                s_next.vis[i] = (s_reg.vis[i] & ~mask) |
                                (cntBytes[i*8 +: 8] & mask);
            end
        end

        // Bus writes into the clock bytes take priority over the copy
        if (commit && wrIsClk) begin
            s_next.vis[s_reg.wrAddr[2:0]] = s_reg.wrData;
            if (s_reg.wrAddr[2:0] == rtc_pkg::IDX_CTRL &&
                s_reg.vis[rtc_pkg::IDX_CTRL][rtc_pkg::WR_HALT_BIT] &&
                !s_reg.wrData[rtc_pkg::WR_HALT_BIT]) begin
                s_next.sec = s_reg.vis[rtc_pkg::IDX_SEC] &
                             rtc_pkg::TIME_MASKS[8 +: 8];
                s_next.min = s_reg.vis[rtc_pkg::IDX_MIN] &
                             rtc_pkg::TIME_MASKS[16 +: 8];
                s_next.hour = s_reg.vis[rtc_pkg::IDX_HOUR] &
                              rtc_pkg::TIME_MASKS[24 +: 8];
                s_next.wday = s_reg.vis[rtc_pkg::IDX_WDAY] &
                              rtc_pkg::TIME_MASKS[32 +: 8];
                s_next.date = s_reg.vis[rtc_pkg::IDX_DATE] &
                              rtc_pkg::TIME_MASKS[40 +: 8];
                s_next.mon = s_reg.vis[rtc_pkg::IDX_MON] &
                             rtc_pkg::TIME_MASKS[48 +: 8];
                s_next.year = s_reg.vis[rtc_pkg::IDX_YEAR] &
                              rtc_pkg::TIME_MASKS[56 +: 8];
            end
        end

        // Read path follows the address combinationally, then one register
        if (addrS >= rtc_pkg::CLOCK_BASE) begin
            rdVal = s_reg.vis[addrS[2:0]];
            if (addrS[2:0] == rtc_pkg::IDX_SEC &&
                s_reg.vis[rtc_pkg::IDX_WDAY][rtc_pkg::RATE_PROBE_BIT] &&
                !s_reg.vis[rtc_pkg::IDX_SEC][rtc_pkg::CRYSTAL_HALT_BIT]) begin
                rdVal[0] = s_reg.probeLsb;
            end
        end else begin
            rdVal = mem[addrS];
        end
        s_next.dataOut = rdVal;
        s_next.dataOe = selS && oeS && !weS && !failS;
        s_next.failOut_n = !failS;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
            s_reg.wday <= rtc_pkg::RST_ONE;
            s_reg.date <= rtc_pkg::RST_ONE;
            s_reg.mon <= rtc_pkg::RST_ONE;
            s_reg.failOut_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Array has no reset: contents are undefined at power-up like any SRAM
    always_ff @(posedge clock) begin
        if (memWrite) begin
            mem[s_reg.wrAddr] <= s_reg.wrData;
        end
    end

    assign dataOut = s_reg.dataOut;
    assign dataOe = s_reg.dataOe;
    assign supply_fail_out_n = s_reg.failOut_n;

endmodule

// File: rtc_pkg.sv
// Shared constants for the timekeeping static RAM
package rtc_pkg;

    // ------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 32768;
    localparam logic [14:0] CLOCK_BASE = 15'h7FF8;

    // ------------------------------------------------------------
    // Clock byte indices within the top eight locations
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_SEC = 3'h1;
    localparam logic [2:0] IDX_MIN = 3'h2;
    localparam logic [2:0] IDX_HOUR = 3'h3;
    localparam logic [2:0] IDX_WDAY = 3'h4;
    localparam logic [2:0] IDX_DATE = 3'h5;
    localparam logic [2:0] IDX_MON = 3'h6;
    localparam logic [2:0] IDX_YEAR = 3'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int WR_HALT_BIT = 7;
    localparam int RD_HALT_BIT = 6;
    localparam int CRYSTAL_HALT_BIT = 7;
    localparam int RATE_PROBE_BIT = 6;

    // Counter-owned bits of each clock byte, index 7 down to 0
    localparam logic [63:0] TIME_MASKS = {8'hFF, 8'h1F, 8'h3F, 8'h07,
                                          8'h3F, 8'h7F, 8'h7F, 8'h00};

    // ------------------------------------------------------------
    // Reset values and BCD limits
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ONE = 8'h01;
    localparam logic [7:0] MAX_SEC = 8'h59;
    localparam logic [7:0] MAX_HOUR = 8'h23;
    localparam logic [7:0] MAX_WDAY = 8'h07;
    localparam logic [7:0] MAX_MON = 8'h12;
    localparam logic [7:0] MAX_YEAR = 8'h99;
    localparam logic [3:0] PIN_IDLE = 4'h7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLOCK_HZ = 250000000;
    localparam longint PROBE_HZ = 512;
    localparam int TICK_CYCLES = int'(CLOCK_HZ / PROBE_HZ);
    localparam logic [8:0] PROBE_LAST = 9'h1FF;

endpackage

// File: pin_sync3.sv
// Three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Pin side and synchronised side
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
        logic [W-1:0] stage3;
        logic [W-1:0] held;
    } sync_t;

    sync_t s_reg;
    sync_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.stage1 = pinIn;
        s_next.stage2 = s_reg.stage1;
        s_next.stage3 = s_reg.stage2;
        for (int i = 0; i < W; i++) begin
            if (s_reg.stage2[i] == s_reg.stage3[i]) begin
                s_next.held[i] = s_reg.stage3[i];
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pinOut = s_reg.held;

endmodule

// File: timekeeping_sram_rtc_checker.sv
// Pin-level assertions for the timekeeping static RAM
`timescale 1ns/1ps
module timekeeping_sram_rtc_checker #(
    parameter int unsigned TICK_CYCLES = rtc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Memory bus pins
    input wire logic [14:0] address_lines,
    input wire logic chipSel_n,
    input wire logic outEn_n,
    input wire logic writeEn_n,
    input wire logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    // Supply monitor
    input wire logic supplyLow,
    input wire logic supply_fail_out_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    logic readNow;
    logic [3:0] readAge_reg;
    assign readNow = !chipSel_n && !outEn_n && writeEn_n && !supplyLow;

    // Saturating age of the last read request seen on the pins
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            readAge_reg <= 4'hF;
        end else if (readNow) begin
            readAge_reg <= 4'h0;
        end else if (readAge_reg != 4'hF) begin
            readAge_reg <= readAge_reg + 4'h1;
        end
    end

    sequence readHeld;
        readNow [*7];
    endsequence
    sequence writeHeld;
        (!chipSel_n && !writeEn_n) [*7];
    endsequence
    sequence supplyGone;
        supplyLow [*6];
    endsequence
    sequence supplyBack;
        $fell(supplyLow) ##1 (!supplyLow) [*3];
    endsequence
    // Plain RAM only: clock bytes may change under a held read
    sequence ramHeld;
        (dataOe && writeEn_n && $stable(address_lines)
            && address_lines < rtc_pkg::CLOCK_BASE) [*8];
    endsequence

    a_read_drives_bus: assert property (readHeld |-> dataOe)
        else $error("data pins idle during a held read");
    a_bus_has_cause: assert property (dataOe |-> readAge_reg < 4'h8)
        else $error("data pins driven with no read request");
    a_write_quiet_bus: assert property (writeHeld |-> !dataOe)
        else $error("data pins driven during a write");
    a_fail_blocks_read: assert property (supplyGone |-> !dataOe)
        else $error("read answered while supply is low");
    a_fail_out_low: assert property (supplyGone |-> !supply_fail_out_n)
        else $error("supply fail output not low");
    a_fail_out_release: assert property (
        supplyBack |-> ##[0:4] supply_fail_out_n)
        else $error("supply fail output not released");
    a_fail_out_high: assert property (
        (!supplyLow) [*8] |-> supply_fail_out_n)
        else $error("supply fail output low with good supply");
    a_ram_read_steady: assert property (ramHeld |=> $stable(dataOut))
        else $error("ram read data moved under a steady address");
endmodule

bind timekeeping_sram_rtc timekeeping_sram_rtc_checker #(
    .TICK_CYCLES(TICK_CYCLES)
) u_checker (.clock, .arst_n, .address_lines, .chipSel_n, .outEn_n,
    .writeEn_n, .dataIn, .dataOut, .dataOe, .supplyLow, .supply_fail_out_n);

// File: sram_host_model.sv
// Host bus model that runs static RAM cycles on the device pins
`timescale 1ns/1ps
module sram_host_model (
    // Clock
    input wire logic clock,
    // Memory bus pins
    output logic [14:0] address_lines,
    output logic chipSel_n,
    output logic outEn_n,
    output logic writeEn_n,
    output logic [7:0] dataIn,
    // Read answer
    input wire logic [7:0] dataOut,
    input wire logic dataOe
);
    initial begin
        address_lines = 15'h0000;
        dataIn = 8'h00;
        chipSel_n = 1'b1;
        outEn_n = 1'b1;
        writeEn_n = 1'b1;
    end

    // Released address and data lines flip rather than hold, so stale values never help
    task automatic release_bus();
        chipSel_n = 1'b1;
        outEn_n = 1'b1;
        writeEn_n = 1'b1;
        address_lines = ~address_lines;
        dataIn = ~dataIn;
        repeat (6) @(negedge clock);
    endtask

    task automatic writeByte(input logic [14:0] a, input logic [7:0] d,
                             input bit csLast);
        @(negedge clock);
        address_lines = a;
        dataIn = d;
        if (csLast) writeEn_n = 1'b0;
        else chipSel_n = 1'b0;
        // Output enable low through a select-last write: the strobe must
        // keep the data pins quiet even with a read otherwise asked for
        outEn_n = !csLast;
        @(negedge clock);
        chipSel_n = 1'b0;
        writeEn_n = 1'b0;
        repeat (8) @(negedge clock);
        writeEn_n = 1'b1;
        repeat (2) @(negedge clock);
        release_bus();
    endtask

    task automatic readByte(input logic [14:0] a, output logic [7:0] d,
                            output bit ok);
        ok = 1'b0;
        @(negedge clock);
        address_lines = a;
        chipSel_n = 1'b0;
        outEn_n = 1'b0;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(negedge clock);
            ok = (dataOe === 1'b1);
        end
        d = dataOut;
        release_bus();
    endtask

    // Sustained read that counts changes of the lowest data bit
    task automatic watchBit(input logic [14:0] a, output int flips);
        logic last;
        flips = 0;
        @(negedge clock);
        address_lines = a;
        chipSel_n = 1'b0;
        outEn_n = 1'b0;
        repeat (8) @(negedge clock);
        last = dataOut[0];
        repeat (64) begin
            @(negedge clock);
            if (dataOe === 1'b1 && dataOut[0] !== last) flips++;
            last = dataOut[0];
        end
        release_bus();
    endtask
endmodule

// File: timekeeping_sram_rtc_bench.sv
// Self-checking bench for the timekeeping static RAM
`timescale 1ns/1ps
module timekeeping_sram_rtc_bench;
    localparam int unsigned TICKS = 4;
    localparam int SECOND = 512 * TICKS;
    localparam logic [14:0] CB = rtc_pkg::CLOCK_BASE;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic supplyLow = 1'b0;
    logic [14:0] address_lines;
    logic chipSel_n, outEn_n, writeEn_n, dataOe, supply_fail_out_n;
    logic [7:0] dataIn, dataOut, d;
    bit ok;
    int flips;
    int bad_count = 0;
    int compares = 0;
    logic [7:0] yrs [3] = '{8'h23, 8'h24, 8'h00};
    logic [7:0] ld [8] = '{8'h00, 8'h59, 8'hD9, 8'hE3, 8'h37, 8'h68,
                           8'hE2, 8'h00};
    logic [7:0] ex [8] = '{8'h00, 8'h00, 8'h80, 8'hC0, 8'h31, 8'h41,
                           8'hE3, 8'h00};

    always #2 clock = ~clock;

    sram_host_model u_sram_host_model (.clock, .address_lines, .chipSel_n,
        .outEn_n, .writeEn_n, .dataIn, .dataOut, .dataOe);
    timekeeping_sram_rtc #(.TICK_CYCLES(TICKS)) u_timekeeping_sram_rtc (
        .clock, .arst_n, .address_lines, .chipSel_n, .outEn_n, .writeEn_n,
        .dataIn, .dataOut, .dataOe, .supplyLow, .supply_fail_out_n);

    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic checkRange(input logic [7:0] got, input logic [7:0] lo,
                              input logic [7:0] hi, input string what);
        compares++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h", $time, what, got);
        end
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] v);
        u_sram_host_model.writeByte(a, v, 1'b0);
    endtask

    task automatic rdCheck(input logic [14:0] a, input logic [7:0] lo,
                           input logic [7:0] hi, input string what);
        logic [7:0] r;
        bit got;
        u_sram_host_model.readByte(a, r, got);
        if (!got) begin
            bad_count++;
            $display("CHECK FAILED at %0t: no answer, %s", $time, what);
            wrap_up();
        end
        checkRange(r, lo, hi, what);
    endtask

    initial begin
        repeat (16) @(negedge clock);
        arst_n = 1'b1;
        wr(15'h0000, 8'hA5);
        u_sram_host_model.writeByte(15'h7FF7, 8'h3C, 1'b1);
        wr(15'h4000, 8'h5A);
        rdCheck(15'h0000, 8'hA5, 8'hA5, "ram low");
        rdCheck(15'h7FF7, 8'h3C, 8'h3C, "ram top");
        rdCheck(15'h4000, 8'h5A, 8'h5A, "ram mid");
        $display("Test ram done");
        // Midnight rollover after 28 February: plain, leap and year 00
        for (int k = 0; k < 3; k++) begin
            ld[7] = yrs[k];
            ex[7] = yrs[k];
            ex[5] = (k == 0) ? 8'h41 : 8'h69;
            ex[6] = (k == 0) ? 8'hE3 : 8'hE2;
            wr(CB, 8'h80);
            for (int i = 1; i < 8; i++) wr(CB + 15'(i), ld[i]);
            wr(CB, 8'h55);
            rdCheck(CB, 8'h55, 8'h55, "control spare");
            rdCheck(CB + 15'h1, 8'h59, 8'h59, "snapshot");
            repeat (SECOND + 64) @(negedge clock);
            rdCheck(CB + 15'h1, 8'h59, 8'h59, "held");
            wr(CB, 8'h00);
            wr(CB, 8'h40);
            rdCheck(CB + 15'h1, 8'h00, 8'h01, "seconds");
            for (int i = 2; i < 8; i++) begin
                rdCheck(CB + 15'(i), ex[i], ex[i], "calendar");
            end
        end
        $display("Test calendar done");
        wr(CB, 8'h80);
        wr(CB + 15'h1, 8'hB0);
        wr(CB, 8'h40);
        repeat (SECOND + 64) @(negedge clock);
        wr(CB, 8'h00);
        wr(CB, 8'h40);
        rdCheck(CB + 15'h1, 8'hB0, 8'hB0, "stopped");
        wr(CB + 15'h1, 8'h30);
        wr(CB, 8'h00);
        repeat (SECOND + 64) @(negedge clock);
        wr(CB, 8'h40);
        rdCheck(CB + 15'h1, 8'h31, 8'h32, "restarted");
        wr(CB, 8'h00);
        $display("Test stop done");
        wr(CB + 15'h4, 8'h41);
        u_sram_host_model.watchBit(CB + 15'h1, flips);
        checkRange(8'(flips), 8'h0E, 8'h12, "probe on");
        wr(CB + 15'h4, 8'h01);
        u_sram_host_model.watchBit(CB + 15'h1, flips);
        checkRange(8'(flips), 8'h00, 8'h01, "probe off");
        u_sram_host_model.watchBit(15'h4000, flips);
        checkRange(8'(flips), 8'h00, 8'h00, "ram steady");
        $display("Test probe done");
        @(negedge clock);
        supplyLow = 1'b1;
        repeat (10) @(negedge clock);
        checkRange({7'h0, supply_fail_out_n}, 8'h0, 8'h0, "fail");
        wr(15'h0000, 8'hFF);
        u_sram_host_model.readByte(15'h0000, d, ok);
        checkRange({7'h0, ok}, 8'h00, 8'h00, "blocked read");
        supplyLow = 1'b0;
        repeat (10) @(negedge clock);
        checkRange({7'h0, supply_fail_out_n}, 8'h1, 8'h1, "ok");
        rdCheck(15'h0000, 8'hA5, 8'hA5, "kept");
        $display("Test supply done");
        wrap_up();
    end
endmodule
